// file: src/ocsync_top.sv
`timescale 1ns/1ps
// Function
// - Slave keeps output clock locked to master
// - Misalignment corrected on next output clock
// - Demux output clock is sample clock over four
// - Master reference marker selects slave clock phase
// - Phase follow set only by register
// - Slaves follow master; masters use reset pulse
// - Reset pulse needs extended mode, off after reset
// - In-phase and quadrature clocks always identical
// - Reset pin assertion taken asynchronously
// - Demux holds clock high; non-demux keeps toggling
// - Narrow pulse possible when entering reset
// - Ninety degree phase syncs four edges later
// - Zero degree phase syncs five edges later
// - Fixed resume delay after sync edge
// - First pulse undetermined, later pulses deterministic
module ocsync_top
  import ocsync_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_clock_enable,
  input wire logic i_sample_clock,
  input wire logic i_extended_control_mode,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic [REG_ADDR_W-1:0] i_reg_addr,
  input wire logic [REG_DATA_W-1:0] i_reg_wdata,
  output logic [REG_DATA_W-1:0] o_reg_rdata,
  input wire logic i_out_clock_sync_reset,
  input wire logic i_reference_phase_in,
  output logic o_reference_phase_out_a,
  output logic o_reference_phase_out_b,
  output logic o_output_clock_in_phase,
  output logic o_output_clock_quadrature
);

  // Register domain state
  logic [REG_DATA_W-1:0] output_phase_config; // Software config word
  logic ecm_meta; // Extended mode pin, first stage
  logic ecm_sync; // Extended mode pin, usable
  logic [XS_W-1:0] to_sample; // Config vector leaving register domain
  logic [XR_W-1:0] st_meta; // Status crossing, first stage
  logic [XR_W-1:0] st_sync; // Status crossing, usable
  // Sample domain state
  logic [XS_W-1:0] xs_meta; // Config crossing, first stage
  logic [XS_W-1:0] xs; // Config crossing, usable
  logic hold_meta; // Reset pin synchroniser, first stage
  logic hold_s; // Reset pin synchroniser, usable
  logic ref_meta; // Master marker, first stage
  logic ref_s; // Master marker, usable
  logic ref_d; // Master marker, delayed for edge detect
  logic [DIV_W-1:0] div_cnt; // Output clock divider
  ocs_state_e state; // Reset pulse sequencer
  logic [2:0] wait_cnt; // Edges to the sync edge
  logic [2:0] mute_cnt; // Resume delay count
  logic pulse_seen; // A first pulse has completed
  logic ref_mark; // Registered marker for followers
  logic [XR_W-1:0] from_sample; // Status leaving sample domain
  // Combinational helpers
  logic ce_s; // Clock enable seen in sample domain
  logic arm_pin; // Reset pin gated by enable
  logic ref_rise; // Master marker edge
  logic sync_edge; // Synchronising sample edge
  logic clk_bit; // Ungated divided clock
  logic muted; // Output held high

  // Extended mode pin comes from outside, two stages
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ecm_meta <= 1'b0;
      ecm_sync <= 1'b0;
    end
    else if (i_clock_enable)
    begin
      ecm_meta <= i_extended_control_mode;
      ecm_sync <= ecm_meta;
    end
  end

  // Config register write
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      output_phase_config <= PHASE_CFG_RESET;
    end
    else if (i_clock_enable && i_reg_write && i_reg_addr == PHASE_CFG_OFFSET)
    begin
      output_phase_config <= i_reg_wdata & PHASE_CFG_MASK;
    end
  end

  // Register read; unmapped offsets read zero
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_reg_rdata <= '0;
    end
    else if (i_clock_enable && i_reg_read)
    begin
      if (i_reg_addr == PHASE_CFG_OFFSET)
      begin
        o_reg_rdata <= output_phase_config;
      end
      else if (i_reg_addr == STATUS_OFFSET)
      begin
        o_reg_rdata <= {{(REG_DATA_W-XR_W){1'b0}}, st_sync};
      end
      else
      begin
        o_reg_rdata <= '0;
      end
    end
  end

  // Vector for the sample domain; fields are quasi-static settings
  always_comb
  begin
    to_sample = '0;
    to_sample[XS_FOLLOW] = output_phase_config[FOLLOW_EN_BIT];
    to_sample[XS_SLAVE] = output_phase_config[SLAVE_BIT];
    to_sample[XS_DEMUX] = output_phase_config[DEMUX_BIT];
    to_sample[XS_PH90] = output_phase_config[PHASE_LO_BIT];
    to_sample[XS_PULSE] = output_phase_config[PULSE_EN_BIT] & ecm_sync;
    to_sample[XS_CE] = i_clock_enable;
  end

  // Per-bit two-stage crossings in both directions
  genvar gi;
  generate
    for (gi = 0; gi < XS_W; gi++)
    begin : g_to_sample
      always_ff @(posedge i_sample_clock or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          xs_meta[gi] <= 1'b0;
          xs[gi] <= 1'b0;
        end
        else
        begin
          xs_meta[gi] <= to_sample[gi];
          xs[gi] <= xs_meta[gi];
        end
      end
    end
    for (gi = 0; gi < XR_W; gi++)
    begin : g_to_reg
      always_ff @(posedge i_clock or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          st_meta[gi] <= 1'b0;
          st_sync[gi] <= 1'b0;
        end
        else if (i_clock_enable)
        begin
          st_meta[gi] <= from_sample[gi];
          st_sync[gi] <= st_meta[gi];
        end
      end
    end
  endgenerate

  assign ce_s = xs[XS_CE];
  assign arm_pin = i_out_clock_sync_reset & xs[XS_PULSE];

  // pin asserts the hold at once, without the clock
  always_ff @(posedge i_sample_clock or negedge i_rst_b or posedge arm_pin)
  begin
    if (!i_rst_b)
    begin
      hold_meta <= 1'b0;
      hold_s <= 1'b0;
    end
    else if (arm_pin)
    begin
      hold_meta <= 1'b1;
      hold_s <= 1'b1;
    end
    else
    begin
      hold_meta <= 1'b0;
      hold_s <= hold_meta;
    end
  end

  // Master marker arrives from another device, two stages then edge
  always_ff @(posedge i_sample_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ref_meta <= 1'b0;
      ref_s <= 1'b0;
      ref_d <= 1'b0;
    end
    else if (ce_s)
    begin
      ref_meta <= i_reference_phase_in;
      ref_s <= ref_meta;
      ref_d <= ref_s;
    end
  end

  // follow only as slave with the feature on
  assign ref_rise = ref_s & ~ref_d & xs[XS_SLAVE] & xs[XS_FOLLOW];
  assign sync_edge = (state == OCS_WAIT) && (wait_cnt == WAIT_ONE);

  // Reset pulse sequencer
  always_ff @(posedge i_sample_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state <= OCS_RUN;
    end
    else if (ce_s)
    begin
      case (state)
        OCS_RUN:
        begin
          if (hold_s)
          begin
            state <= OCS_HOLD;
          end
        end
        OCS_HOLD:
        begin
          // first release keeps its arbitrary phase
          if (!hold_s)
          begin
            state <= pulse_seen ? OCS_WAIT : OCS_RUN;
          end
        end
        OCS_WAIT:
        begin
          if (sync_edge)
          begin
            state <= OCS_MUTE;
          end
        end
        OCS_MUTE:
        begin
          if (hold_s)
          begin
            state <= OCS_HOLD;
          end
          else if (mute_cnt == WAIT_ONE)
          begin
            state <= OCS_RUN;
          end
        end
        default:
        begin
          state <= OCS_RUN;
        end
      endcase
    end
  end

  // Count to the sync edge, loaded while held
  always_ff @(posedge i_sample_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wait_cnt <= '0;
    end
    else if (ce_s)
    begin
      if (state == OCS_HOLD)
      begin
        // four edges in ninety degree mode
        // five edges in zero degree mode
        wait_cnt <= (xs[XS_PH90] ? SYNC_DLY_90 : SYNC_DLY_0) - WAIT_ONE;
      end
      else if (state == OCS_WAIT)
      begin
        wait_cnt <= wait_cnt - WAIT_ONE;
      end
    end
  end

  // Fixed resume delay, equal on every device
  always_ff @(posedge i_sample_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      mute_cnt <= '0;
    end
    else if (ce_s)
    begin
      if (sync_edge)
      begin
        mute_cnt <= RESUME_DLY;
      end
      else if (state == OCS_MUTE)
      begin
        mute_cnt <= mute_cnt - WAIT_ONE;
      end
    end
  end

  // First pulse memory, cleared only by power-up reset
  always_ff @(posedge i_sample_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pulse_seen <= 1'b0;
    end
    else if (ce_s && state == OCS_HOLD && !hold_s)
    begin
      pulse_seen <= 1'b1;
    end
  end

  // Divider; sync edge restarts it, slave marker realigns it
  always_ff @(posedge i_sample_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      div_cnt <= DIV_START;
    end
    else if (ce_s)
    begin
      if (sync_edge)
      begin
        div_cnt <= DIV_START;
      end
      else if (ref_rise && state == OCS_RUN)
      begin
        // phase follow, no sync pulse needed
        div_cnt <= REF_ALIGN_CNT;
      end
      else
      begin
        // four sample phases per output clock in demux mode, two otherwise
        div_cnt <= div_cnt + DIV_STEP;
      end
    end
  end

  // Marker for followers, both pins driven for tree fan-out
  always_ff @(posedge i_sample_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ref_mark <= 1'b0;
    end
    else if (ce_s)
    begin
      // every device can lead a subtree
      ref_mark <= (div_cnt == DIV_START) && (state == OCS_RUN);
    end
  end

  assign o_reference_phase_out_a = ref_mark;
  assign o_reference_phase_out_b = ref_mark;

  // held high only in demux mode
  // async hold can clip a low phase short
  assign muted = xs[XS_DEMUX] & (hold_s | (state != OCS_RUN));
  assign clk_bit = xs[XS_DEMUX] ? div_cnt[1] : div_cnt[0];

  // both output clocks from one source
  assign o_output_clock_in_phase = muted | clk_bit;
  assign o_output_clock_quadrature = muted | clk_bit;

  // Status back to the register domain
  always_comb
  begin
    from_sample = '0;
    from_sample[ST_HOLD_BIT] = (state != OCS_RUN);
    from_sample[ST_DET_BIT] = pulse_seen;
  end

  // Release sequence, ninety degrees, second or later pulse
  sequence s_release_90;
    $fell(hold_s) && state == OCS_HOLD && pulse_seen && xs[XS_PH90];
  endsequence

  // Release sequence, zero degrees, second or later pulse
  sequence s_release_0;
    $fell(hold_s) && state == OCS_HOLD && pulse_seen && !xs[XS_PH90];
  endsequence

  // Two muted steps while the restarted divider counts up from zero
  sequence s_mute_steps;
    state == OCS_MUTE && div_cnt == DIV_START ##1 state == OCS_MUTE && div_cnt == DIV_STEP;
  endsequence

  a_sync_ninety_deg: assert property (
    @(posedge i_sample_clock) disable iff (!i_rst_b || !ce_s)
    s_release_90 |-> !sync_edge [*3] ##1 sync_edge)
    else $error("sync edge not four edges after release at 90 deg");

  a_sync_zero_deg: assert property (
    @(posedge i_sample_clock) disable iff (!i_rst_b || !ce_s)
    s_release_0 |-> !sync_edge [*4] ##1 sync_edge)
    else $error("sync edge not five edges after release at 0 deg");

  a_resume_fixed_delay: assert property (
    @(posedge i_sample_clock) disable iff (!i_rst_b || !ce_s || hold_s)
    sync_edge |=> s_mute_steps ##1 state == OCS_RUN)
    else $error("output clock did not resume after fixed delay");

  a_quad_in_phase: assert property (
    @(posedge i_sample_clock) disable iff (!i_rst_b)
    o_output_clock_in_phase == o_output_clock_quadrature)
    else $error("in-phase and quadrature clocks differ");

  a_demux_hold_high: assert property (
    @(posedge i_sample_clock) disable iff (!i_rst_b)
    xs[XS_DEMUX] && hold_s |-> o_output_clock_in_phase)
    else $error("demux output clock not held high in reset");

  a_nondemux_toggles: assert property (
    @(posedge i_sample_clock) disable iff (!i_rst_b || !ce_s)
    !xs[XS_DEMUX] && $past(!xs[XS_DEMUX]) && $past(ce_s) && !$past(sync_edge)
      && !$past(ref_rise) |-> o_output_clock_in_phase != $past(o_output_clock_in_phase))
    else $error("non-demux output clock stopped toggling");

  a_slave_follow: assert property (
    @(posedge i_sample_clock) disable iff (!i_rst_b || !ce_s)
    ref_rise && state == OCS_RUN && !sync_edge |=> div_cnt == REF_ALIGN_CNT)
    else $error("slave divider not aligned to master marker");

  a_pulse_gated: assert property (
    @(posedge i_sample_clock) disable iff (!i_rst_b)
    !xs[XS_PULSE] [*3] |-> !hold_s)
    else $error("reset pulse acted while disabled");

  a_pin_async_hold: assert property (
    @(posedge i_sample_clock) disable iff (!i_rst_b)
    arm_pin |-> hold_s ##1 (hold_s || state != OCS_RUN))
    else $error("reset pin assertion not held");

  a_first_undetermined: assert property (
    @(posedge i_sample_clock) disable iff (!i_rst_b || !ce_s)
    state == OCS_HOLD && !hold_s && !pulse_seen |=> state == OCS_RUN && pulse_seen)
    else $error("first release not handled as undetermined");

endmodule : ocsync_top

// file: src/ocsync_pkg.sv
package ocsync_pkg;
  // Register map, offsets on the documented register port
  localparam int REG_ADDR_W = 4;
  localparam int REG_DATA_W = 16;
  localparam logic [3:0] PHASE_CFG_OFFSET = 4'hE;
  localparam logic [3:0] STATUS_OFFSET = 4'hF;
  localparam logic [15:0] PHASE_CFG_RESET = 16'h0000;
  localparam logic [15:0] PHASE_CFG_MASK = 16'h003F;
  // Field positions in output_phase_config
  localparam int FOLLOW_EN_BIT = 0;
  localparam int SLAVE_BIT = 1;
  localparam int DEMUX_BIT = 2;
  localparam int PHASE_LO_BIT = 3;
  localparam int PHASE_HI_BIT = 4;
  localparam int PULSE_EN_BIT = 5;
  // Field positions in the status word
  localparam int ST_HOLD_BIT = 0;
  localparam int ST_DET_BIT = 1;
  // Positions in the vector crossed into the sample domain
  localparam int XS_FOLLOW = 0;
  localparam int XS_SLAVE = 1;
  localparam int XS_DEMUX = 2;
  localparam int XS_PH90 = 3;
  localparam int XS_PULSE = 4;
  localparam int XS_CE = 5;
  localparam int XS_W = 6;
  // Status vector width crossed back
  localparam int XR_W = 2;
  // Sample-clock edges from first edge after release to the sync edge
  localparam logic [2:0] SYNC_DLY_90 = 3'h4;
  localparam logic [2:0] SYNC_DLY_0 = 3'h5;
  localparam logic [2:0] WAIT_ONE = 3'h1;
  // Fixed resume delay after the sync edge, sample cycles
  localparam logic [2:0] RESUME_DLY = 3'h2;
  // Divider: four sample phases per output clock in demux mode
  localparam int DIV_W = 2;
  localparam logic [1:0] DIV_START = 2'h0;
  localparam logic [1:0] DIV_STEP = 2'h1;
  // Divider value a slave loads when the master marker is detected
  localparam logic [1:0] REF_ALIGN_CNT = 2'h0;
  // Reset pulse sequencer states
  typedef enum logic [1:0] {OCS_RUN, OCS_HOLD, OCS_WAIT, OCS_MUTE} ocs_state_e;
endpackage : ocsync_pkg

// file: dv/ocsync_partner.sv
`timescale 1ns/1ps
// Master converter and system reset logic at the far side
module ocsync_partner
(
  input wire logic i_sample_clock,
  input wire logic i_rst_b,
  output logic o_reference_phase,
  output logic o_sync_reset
);
  // Master divider count
  logic [1:0] phase_cnt;
  // Count value that raises the marker; moved to upset a slave
  logic [1:0] marker_at = 2'h0;

  initial o_sync_reset = 1'b0;

  always_ff @(posedge i_sample_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      phase_cnt <= 2'h0;
      o_reference_phase <= 1'b0;
    end
    else
    begin
      phase_cnt <= phase_cnt + 2'h1;
      o_reference_phase <= (phase_cnt == marker_at);
    end
  end

  // Shift the master phase
  task automatic set_phase(input logic [1:0] p);
    marker_at = p;
  endtask : set_phase

  // system pulse, released just after a sample edge
  task automatic send_pulse(input int width);
    @(posedge i_sample_clock);
    o_sync_reset <= 1'b1;
    repeat (width) @(posedge i_sample_clock);
    o_sync_reset <= 1'b0;
  endtask : send_pulse
endmodule : ocsync_partner

// file: dv/tb_output_clock_sync.sv
`timescale 1ns/1ps
// Self-checking bench for the output clock alignment block
module tb_output_clock_sync
  import ocsync_pkg::*;
;
  logic clock = 1'b0;
  logic samp;
  logic rst_b;
  logic clk_en;
  logic ext_mode;
  logic wr;
  logic rd;
  logic [REG_ADDR_W-1:0] addr;
  logic [REG_DATA_W-1:0] wdata;
  logic [REG_DATA_W-1:0] rdata;
  logic ref_in;
  logic sync_rst;
  logic ref_a;
  logic ref_b;
  logic oc_i;
  logic oc_q;
  int checks = 0;
  int n_errors = 0;

  // Register clock
  always #12.5 clock = ~clock;

  // Sample clock, offset so its edges never meet the register clock
  initial
  begin
    samp = 1'b0;
    #7.3;
    forever #40 samp = ~samp;
  end

  ocsync_top i_dut (
    .i_clock(clock),
    .i_rst_b(rst_b),
    .i_clock_enable(clk_en),
    .i_sample_clock(samp),
    .i_extended_control_mode(ext_mode),
    .i_reg_write(wr),
    .i_reg_read(rd),
    .i_reg_addr(addr),
    .i_reg_wdata(wdata),
    .o_reg_rdata(rdata),
    .i_out_clock_sync_reset(sync_rst),
    .i_reference_phase_in(ref_in),
    .o_reference_phase_out_a(ref_a),
    .o_reference_phase_out_b(ref_b),
    .o_output_clock_in_phase(oc_i),
    .o_output_clock_quadrature(oc_q)
  );

  ocsync_partner i_partner (
    .i_sample_clock(samp),
    .i_rst_b(rst_b),
    .o_reference_phase(ref_in),
    .o_sync_reset(sync_rst)
  );

  // Verdict and end of run
  task automatic final_report;
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  // One comparison
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Write strobe for one cycle
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : reg_wr

  // Read strobe; data is registered at the strobe edge
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  // Wait on sample falling edges, where outputs are settled
  task automatic se(input int n);
    repeat (n) @(negedge samp);
  endtask : se

  // Config write, then let it cross into the sample domain
  task automatic cfg(input logic [15:0] d);
    reg_wr(PHASE_CFG_OFFSET, d);
    se(6);
  endtask : cfg

  // Toggles of the output clock and marker samples over n cycles
  task automatic count_tog(input int n, output logic [15:0] tog, output logic [15:0] mark);
    logic prev;
    prev = oc_i;
    tog = 16'h0000;
    mark = 16'h0000;
    repeat (n)
    begin
      @(negedge samp);
      if (oc_i !== prev)
        tog++;
      if (ref_a === 1'b1)
        mark++;
      prev = oc_i;
      check({14'h0000, oc_q, ref_b}, {14'h0000, oc_i, ref_a});
    end
  endtask : count_tog

  // Register reset values, masking, enable and unmapped offset
  task automatic t_regs;
    logic [15:0] d;
    reg_rd(STATUS_OFFSET, d);
    check(d, 16'h0000);
    reg_rd(PHASE_CFG_OFFSET, d);
    check(d, PHASE_CFG_RESET);
    @(posedge clock);
    clk_en <= 1'b0;
    reg_wr(PHASE_CFG_OFFSET, 16'hFFFF);
    @(posedge clock);
    clk_en <= 1'b1;
    reg_rd(PHASE_CFG_OFFSET, d);
    check(d, PHASE_CFG_RESET);
    reg_wr(PHASE_CFG_OFFSET, 16'hFFFF);
    reg_wr(4'h3, 16'h1234);
    reg_rd(PHASE_CFG_OFFSET, d);
    check(d, PHASE_CFG_MASK);
    reg_rd(4'h3, d);
    check(d, 16'h0000);
    cfg(16'h0000);
    $display("test regs done");
  endtask : t_regs

  // Divide ratios and behaviour while the pulse pin is high
  task automatic t_modes;
    logic [15:0] t;
    logic [15:0] m;
    logic [15:0] d;
    count_tog(8, t, m);
    check(t, 16'h0008);
    cfg(16'h0004);
    count_tog(8, t, m);
    check(t, 16'h0004);
    check(m, 16'h0002);
    // Pulse enabled in the register but extended mode off
    cfg(16'h0024);
    fork
      i_partner.send_pulse(8);
      begin
        se(3);
        count_tog(4, t, m);
      end
    join
    check(t, 16'h0002);
    se(16);
    @(posedge clock);
    ext_mode <= 1'b1;
    // Dummy pulse in non-demux mode: clock keeps running
    cfg(16'h0020);
    fork
      i_partner.send_pulse(8);
      begin
        se(3);
        count_tog(4, t, m);
      end
    join
    check(t, 16'h0004);
    se(16);
    reg_rd(STATUS_OFFSET, d);
    check(d, 16'h0002);
    // Demux: held high while the pin is high
    cfg(16'h0024);
    fork
      i_partner.send_pulse(8);
      begin
        se(3);
        count_tog(4, t, m);
      end
    join
    check(t, 16'h0000);
    check({15'h0000, oc_i}, 16'h0001);
    se(16);
    $display("test modes done");
  endtask : t_modes

  // Sample cycles from pin release to the first low output clock
  task automatic sync_edges(output logic [15:0] n);
    n = 16'h0000;
    i_partner.send_pulse(6);
    while (oc_i !== 1'b0 && n < 16'h0028)
    begin
      @(negedge samp);
      n++;
    end
    se(12);
  endtask : sync_edges

  // Release latency for both phase settings, repeated pulses
  task automatic t_sync;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    cfg(16'h002C);
    sync_edges(a);
    sync_edges(b);
    check(b, a);
    // Two synchroniser edges, the sync delay, one full output period, then the sampling edge
    check(a, {13'h0000, SYNC_DLY_90} + 16'h0007);
    check({15'h0000, a >= 16'h0006}, 16'h0001);
    cfg(16'h0024);
    sync_edges(c);
    check(c, a + 16'h0001);
    sync_edges(b);
    check(b, c);
    $display("test sync done");
  endtask : t_sync

  // Cycles from the master marker to the next output rise
  task automatic ref_offset(output logic [15:0] off);
    logic prev;
    off = 16'h00FF;
    while (ref_in !== 1'b1)
      @(negedge samp);
    prev = oc_i;
    for (int j = 1; j < 9; j++)
    begin
      @(negedge samp);
      if (oc_i === 1'b1 && prev === 1'b0 && off == 16'h00FF)
        off = j[15:0];
      prev = oc_i;
    end
  endtask : ref_offset

  // Slave follows the master marker, also after an upset
  task automatic t_follow;
    logic [15:0] o1;
    logic [15:0] o2;
    cfg(16'h0007);
    se(12);
    ref_offset(o1);
    i_partner.set_phase(2'h2);
    se(8);
    ref_offset(o2);
    check(o2, o1);
    i_partner.set_phase(2'h1);
    se(8);
    ref_offset(o2);
    check(o2, o1);
    $display("test follow done");
  endtask : t_follow

  // Main sequence
  initial
  begin
    // Idle levels, reset asserted from time zero
    rst_b <= 1'b0;
    clk_en <= 1'b1;
    ext_mode <= 1'b0;
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= 4'h0;
    wdata <= 16'h0000;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    t_modes();
    t_sync();
    t_follow();
    final_report();
  end

  // Hang guard, far beyond the expected run
  initial
  begin
    #500us;
    n_errors++;
    final_report();
  end
endmodule : tb_output_clock_sync
